// file: rtl/ebm_master.sv
/*
  External asynchronous bus master with dynamic 8/16-bit port sizing.
  Assumes req is only raised while busy is low; pins are asynchronous to clock.
*/
`timescale 1ns/1ps
module ebm_master (
  input wire logic clock,
  input wire logic srst,
  input wire logic req,
  input wire logic [ebm_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_write,
  input wire logic [2:0] req_len,
  input wire logic [ebm_pkg::OPND_W-1:0] req_wdata,
  input wire logic req_supervisor,
  input wire logic req_program,
  input wire logic req_ctrl_space,
  output logic busy,
  output logic done,
  output logic fault,
  output logic [ebm_pkg::OPND_W-1:0] rdata,
  output logic [ebm_pkg::ADDR_W-1:0] addr,
  output logic address_strobe_n,
  output logic data_strobe_n,
  output logic read_write,
  output logic [1:0] transfer_size_code,
  output logic [2:0] space_code,
  output logic [ebm_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [ebm_pkg::DATA_W-1:0] data_in,
  input wire logic [1:0] port_width_ack_n,
  input wire logic bus_fault_n,
  output logic cycle_start,
  output logic cycle_active
);
  ebm_pkg::ebm_state_t state;
  logic [1:0] ack_m, ack_s;
  logic fault_m, fault_s;
  logic [ebm_pkg::DATA_W-1:0] din_m, din_s;
  logic [2:0] remaining;
  logic [ebm_pkg::OPND_W-1:0] op_shift;
  logic [2:0] step;
  logic [2:0] step_q;
  logic acked;
  logic op_write_q;

  // pins are asynchronous: two flops before use
  always_ff @(posedge clock) begin
    ack_m <= port_width_ack_n;
    ack_s <= ack_m;
    fault_m <= bus_fault_n;
    fault_s <= fault_m;
    din_m <= data_in;
    din_s <= din_m;
  end

  assign acked = (ack_s == ebm_pkg::ACK_PORT8) || (ack_s == ebm_pkg::ACK_PORT16);

  // bytes moved this cycle, from port width and byte offset
  always_comb begin
    if (ack_s == ebm_pkg::ACK_PORT8 || addr[0] || remaining == ebm_pkg::STEP_ONE) begin
      step = ebm_pkg::STEP_ONE;
    end else begin
      step = ebm_pkg::STEP_TWO;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= ebm_pkg::ST_IDLE;
    end else begin
      unique case (state)
        ebm_pkg::ST_IDLE: begin
          if (req) begin
            state <= ebm_pkg::ST_START;
          end
        end
        ebm_pkg::ST_START: state <= ebm_pkg::ST_ASRT;
        ebm_pkg::ST_ASRT: state <= ebm_pkg::ST_DRIVE;
        ebm_pkg::ST_DRIVE: state <= ebm_pkg::ST_WAIT;
        ebm_pkg::ST_WAIT: begin
          if (!fault_s || acked) begin
            state <= ebm_pkg::ST_NEG;
          end
        end
        ebm_pkg::ST_NEG: begin
          if (remaining == 3'h0 || fault) begin
            state <= ebm_pkg::ST_IDLE;
          end else begin
            state <= ebm_pkg::ST_START;
          end
        end
      endcase
    end
  end

  // operand bookkeeping, address and direction
  always_ff @(posedge clock) begin
    if (srst) begin
      remaining <= 3'h0;
      step_q <= 3'h0;
      op_shift <= '0;
      addr <= '0;
      read_write <= 1'b1;
      transfer_size_code <= 2'h0;
      space_code <= 3'h0;
    end else if (state == ebm_pkg::ST_IDLE && req) begin
      remaining <= req_len;
      op_shift <= req_wdata << (8 * (4 - int'(req_len)));
      addr <= req_addr;
      if (req_ctrl_space) begin
        space_code <= ebm_pkg::SPACE_CTRL;
      end else begin
        space_code <= {req_supervisor, req_program, !req_program};
      end
    end else if (state == ebm_pkg::ST_START) begin
      read_write <= !op_write_q;
      transfer_size_code <= remaining[1:0];
    end else if (state == ebm_pkg::ST_WAIT && fault_s && acked) begin
      remaining <= remaining - step;
      op_shift <= op_shift << (8 * int'(step));
      step_q <= step;
    end else if (state == ebm_pkg::ST_NEG && !fault) begin
      // address moves only as the strobe is released
      addr <= addr + ebm_pkg::ADDR_W'(step_q);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      op_write_q <= 1'b0;
    end else if (state == ebm_pkg::ST_IDLE && req) begin
      op_write_q <= req_write;
    end
  end

  // strobes and data drive
  always_ff @(posedge clock) begin
    if (srst) begin
      address_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
      data_oe <= 1'b0;
      data_out <= '0;
    end else begin
      unique case (state)
        ebm_pkg::ST_ASRT: begin
          address_strobe_n <= 1'b0;
          if (!op_write_q) begin
            data_strobe_n <= 1'b0;
          end
        end
        ebm_pkg::ST_DRIVE: begin
          if (op_write_q) begin
            data_oe <= 1'b1;
            if (addr[0]) begin
              data_out <= {op_shift[31:24], op_shift[31:24]};
            end else begin
              data_out <= op_shift[31:16];
            end
          end
        end
        ebm_pkg::ST_WAIT: begin
          if (op_write_q) begin
            data_strobe_n <= 1'b0;
          end
        end
        ebm_pkg::ST_NEG: begin
          address_strobe_n <= 1'b1;
          data_strobe_n <= 1'b1;
          data_oe <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // read capture and completion
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata <= '0;
      fault <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
      cycle_start <= 1'b0;
      cycle_active <= 1'b0;
    end else begin
      done <= 1'b0;
      cycle_start <= (state == ebm_pkg::ST_START);
      cycle_active <= (state == ebm_pkg::ST_START) || (state == ebm_pkg::ST_ASRT) ||
                      (state == ebm_pkg::ST_DRIVE) || (state == ebm_pkg::ST_WAIT);
      if (state == ebm_pkg::ST_IDLE && req) begin
        busy <= 1'b1;
        fault <= 1'b0;
        rdata <= '0;
      end
      if (state == ebm_pkg::ST_WAIT && !fault_s) begin
        fault <= 1'b1;
      end else if (state == ebm_pkg::ST_WAIT && acked && !op_write_q) begin
        if (step == ebm_pkg::STEP_TWO) begin
          rdata <= {rdata[15:0], din_s};
        end else if (ack_s == ebm_pkg::ACK_PORT16 && addr[0]) begin
          rdata <= {rdata[23:0], din_s[7:0]};
        end else begin
          rdata <= {rdata[23:0], din_s[15:8]};
        end
      end
      if (state == ebm_pkg::ST_NEG && (remaining == 3'h0 || fault)) begin
        done <= 1'b1;
        busy <= 1'b0;
      end
    end
  end

  as_after_start_a: assert property (@(posedge clock) disable iff (srst)
    cycle_start |=> $fell(address_strobe_n)) else $error("strobe not one step after start");
  addr_hold_a: assert property (@(posedge clock) disable iff (srst)
    !address_strobe_n && !$past(address_strobe_n) |-> $stable(addr) && $stable(space_code))
    else $error("address moved under strobe");
  read_ds_a: assert property (@(posedge clock) disable iff (srst)
    $fell(address_strobe_n) && read_write |-> $fell(data_strobe_n)) else $error("read data strobe late");
  write_ds_a: assert property (@(posedge clock) disable iff (srst)
    $fell(address_strobe_n) && !read_write |-> data_strobe_n ##1 data_strobe_n ##1 !data_strobe_n)
    else $error("write data strobe not one clock after address strobe");
  write_data_a: assert property (@(posedge clock) disable iff (srst)
    $fell(address_strobe_n) && !read_write |-> !data_oe ##1 data_oe) else $error("write data not half clock late");
  full_drive_a: assert property (@(posedge clock) disable iff (srst)
    data_oe |-> !read_write && !address_strobe_n) else $error("data driven outside write");
  dir_stable_a: assert property (@(posedge clock) disable iff (srst)
    !address_strobe_n |-> $stable(read_write) && $stable(transfer_size_code)) else $error("direction moved");
  size_code_a: assert property (@(posedge clock) disable iff (srst)
    $fell(address_strobe_n) |-> transfer_size_code == remaining[1:0]) else $error("size code wrong");
  strobe_neg_a: assert property (@(posedge clock) disable iff (srst)
    state == ebm_pkg::ST_NEG |=> address_strobe_n && data_strobe_n) else $error("strobes not negated");
  fault_end_a: assert property (@(posedge clock) disable iff (srst)
    state == ebm_pkg::ST_WAIT && !fault_s |=> ##1 done && fault) else $error("fault not reported");
  long_read_c: cover property (@(posedge clock) disable iff (srst)
    state == ebm_pkg::ST_IDLE && req && !req_write && req_len == ebm_pkg::LEN_LONG);
  write_c: cover property (@(posedge clock) disable iff (srst) done && !fault && op_write_q);
  fault_c: cover property (@(posedge clock) disable iff (srst) done && fault);
endmodule

// file: rtl/ebm_pkg.sv
/*
  Shared constants and types for the external bus master.
  Assumes a single 40 MHz clock; each state step is half a bus clock period.
*/
// What this block does
// - 24 address outputs, 16-bit two-way data bus, dynamic 8/16-bit port sizing.
// - byte, word, long-word operands; extra bus cycles when one cycle cannot finish.
// - drive address of next (most significant) byte; hold while address strobe asserted.
// - assert address strobe half a clock after the cycle begins.
// - read data captured at the end of the wait step, one step before the strobes are negated.
// - write cycles drive all sixteen data lines regardless of width or size.
// - write data placed half a clock after address strobe.
// - read cycles assert data strobe with address strobe; slave then drives data.
// - write cycles assert data strobe one clock after address strobe.
// - direction changes only at cycle start, only on read/write turn; stable under strobe.
// - size outputs show bytes remaining: 01 byte, 10 word, 11 three, 00 long.
// - three-bit space code valid under strobe: 001,010,101,110, and 7 for control space.
// - supervisor/user from status bit; program/data from addressing mode and instruction.
// - all port widths use asynchronous cycles ended by the port width acknowledge.
// - cycle start and active marks let chip-select logic follow external transfers.
// - bus fault input ends an improperly terminated cycle; the cycle counts as failed.
package ebm_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int OPND_W = 32;
  localparam logic [2:0] LEN_BYTE = 3'h1;
  localparam logic [2:0] LEN_WORD = 3'h2;
  localparam logic [2:0] LEN_LONG = 3'h4;
  localparam logic [1:0] ACK_WAIT = 2'h3;
  localparam logic [1:0] ACK_PORT8 = 2'h2;
  localparam logic [1:0] ACK_PORT16 = 2'h1;
  localparam logic [2:0] SPACE_CTRL = 3'h7;
  localparam logic [2:0] STEP_ONE = 3'h1;
  localparam logic [2:0] STEP_TWO = 3'h2;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_START = 6'h02,
    ST_ASRT = 6'h04,
    ST_DRIVE = 6'h08,
    ST_WAIT = 6'h10,
    ST_NEG = 6'h20
  } ebm_state_t;
endpackage

// file: testbench/ebm_master_tb.sv
/*
  Self-checking bench for the bus master: one task per scenario.
  Assumes ebm_slave_model answers the bus; 40 MHz clock, sync reset.
*/
`timescale 1ns/1ps
module ebm_master_tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic req = 1'b0;
  logic [23:0] req_addr = 24'h0;
  logic req_write = 1'b0;
  logic [2:0] req_len = 3'h1;
  logic [31:0] req_wdata = 32'h0;
  logic sup = 1'b0, prog = 1'b0, ctl = 1'b0, port8 = 1'b0, fault_mode = 1'b0;
  logic [3:0] wait_n = 4'h0;
  logic busy, done, fault, as_n, ds_n, rw, oe, cstart, bus_fault_n_n, cact;
  logic [1:0] ca;
  logic [31:0] rdata;
  logic [23:0] addr, al;
  logic [1:0] size, ack_n;
  logic [1:0] sizes [4];
  logic [2:0] space, sp;
  logic [15:0] dout, din, wlast;
  logic rw_s, cs_ok;
  int bad_count = 0, checks = 0, ncyc, ds_lag, oe_lag, as_cnt;
  always #12.5 clock = ~clock;
  ebm_master dut (.clock(clock), .srst(srst), .req(req), .req_addr(req_addr), .req_write(req_write),
    .req_len(req_len), .req_wdata(req_wdata), .req_supervisor(sup), .req_program(prog),
    .req_ctrl_space(ctl), .busy(busy), .done(done), .fault(fault), .rdata(rdata), .addr(addr),
    .address_strobe_n(as_n), .data_strobe_n(ds_n), .read_write(rw), .transfer_size_code(size),
    .space_code(space), .data_out(dout), .data_oe(oe), .data_in(din), .port_width_ack_n(ack_n),
    .bus_fault_n(bus_fault_n_n), .cycle_start(cstart), .cycle_active(cact));
  ebm_slave_model partner (.clock(clock), .address_strobe_n(as_n), .data_strobe_n(ds_n),
    .read_write(rw), .addr(addr), .data_out(dout), .port8(port8), .wait_n(wait_n),
    .fault_mode(fault_mode), .data_in(din), .port_width_ack_n(ack_n), .bus_fault_n(bus_fault_n_n), .wlast(wlast));
  function automatic logic [31:0] pat4(input logic [23:0] a);
    return {a[7:0] ^ 8'h5A, (a[7:0] + 8'h1) ^ 8'h5A, (a[7:0] + 8'h2) ^ 8'h5A, (a[7:0] + 8'h3) ^ 8'h5A};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic run_op(input logic [23:0] a, input logic w, input logic [2:0] len, input logic [31:0] wd);
    logic pas, pds, poe, pcs;
    pas = 1'b1;
    pds = 1'b1;
    poe = 1'b0;
    pcs = 1'b0;
    ncyc = 0;
    as_cnt = 0;
    ds_lag = 0;
    oe_lag = 0;
    ca = 2'h0;
    @(posedge clock);
    req_addr <= a;
    req_write <= w;
    req_len <= len;
    req_wdata <= wd;
    req <= 1'b1;
    @(posedge clock);
    req <= 1'b0;
    for (int n = 0; n < 300; n++) begin
      @(negedge clock);
      if (!as_n) begin
        as_cnt++;
        if (pas && ncyc < 4) begin
          sizes[ncyc] = size;
          ncyc++;
          sp = space;
          rw_s = rw;
          al = addr;
          cs_ok = pcs;
          ca = {cact, busy};
        end
        if (!ds_n && pds) ds_lag = as_cnt;
        if (oe && !poe) oe_lag = as_cnt;
      end else as_cnt = 0;
      pas = as_n;
      pds = ds_n;
      poe = oe;
      pcs = cstart;
      if (done) break;
      if (n == 299) begin
        bad_count++;
        report_and_stop();
      end
    end
    check("start then strobe", cs_ok, 1'b1);
    check("idle strobes", {as_n, ds_n, oe, cact, busy}, 5'b11000);
    check("active busy", ca, 2'b11);
    check("fault flag", fault, fault_mode);
  endtask
  task automatic s_write_word;
    run_op(24'h001000, 1'b1, 3'h2, 32'h0000BEEF);
    check("cycles", ncyc, 1);
    check("size", sizes[0], 2'h2);
    check("dir", rw_s, 1'b0);
    check("space", sp, 3'h5);
    check("ds lag", ds_lag, 3);
    check("data lag", oe_lag, 2);
    check("wdata", wlast, 16'hBEEF);
    check("addr", al, 24'h001000);
  endtask
  task automatic s_read_long16;
    wait_n <= 4'h2;
    run_op(24'h002000, 1'b0, 3'h4, 32'h0);
    check("cycles", ncyc, 2);
    check("size0", sizes[0], 2'h0);
    check("size1", sizes[1], 2'h2);
    check("space", sp, 3'h2);
    check("ds lag", ds_lag, 1);
    check("addr", al, 24'h002002);
    check("rdata", rdata, pat4(24'h002000));
  endtask
  task automatic s_read_long8;
    port8 <= 1'b1;
    run_op(24'h003001, 1'b0, 3'h4, 32'h0);
    check("cycles", ncyc, 4);
    check("sizes", {sizes[0], sizes[1], sizes[2], sizes[3]}, 8'h39);
    check("addr", al, 24'h003004);
    check("rdata", rdata, pat4(24'h003001));
  endtask
  task automatic s_write_byte_odd8;
    @(posedge clock);
    ctl <= 1'b1;
    run_op(24'h004003, 1'b1, 3'h1, 32'h000000C7);
    check("size", sizes[0], 2'h1);
    check("space", sp, ebm_pkg::SPACE_CTRL);
    check("wdata", wlast, 16'hC7C7);
    @(posedge clock);
    port8 <= 1'b0;
    ctl <= 1'b0;
  endtask
  task automatic s_fault;
    @(posedge clock);
    sup <= 1'b0;
    fault_mode <= 1'b1;
    run_op(24'h005000, 1'b0, 3'h2, 32'h0);
    check("space", sp, 3'h1);
    check("fault", fault, 1'b1);
    fault_mode <= 1'b0;
  endtask
  initial begin
    sup = 1'b1;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    s_write_word();
    @(posedge clock);
    prog <= 1'b1;
    sup <= 1'b0;
    s_read_long16();
    s_read_long8();
    @(posedge clock);
    prog <= 1'b0;
    s_write_byte_odd8();
    s_fault();
    report_and_stop();
  end
endmodule

// file: testbench/ebm_slave_model.sv
/*
  Behavioural far-side device: memory or peripheral on the external bus.
  Assumes the master's strobes and address come from the design; ties nothing.
*/
`timescale 1ns/1ps
module ebm_slave_model (
  input wire logic clock,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  input wire logic [ebm_pkg::ADDR_W-1:0] addr,
  input wire logic [ebm_pkg::DATA_W-1:0] data_out,
  input wire logic port8,
  input wire logic [3:0] wait_n,
  input wire logic fault_mode,
  output logic [ebm_pkg::DATA_W-1:0] data_in,
  output logic [1:0] port_width_ack_n,
  output logic bus_fault_n,
  output logic [ebm_pkg::DATA_W-1:0] wlast
);
  logic [3:0] cnt = 4'h0;
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  initial begin
    data_in = 16'hA5C3;
    port_width_ack_n = 2'h3;
    bus_fault_n = 1'b1;
    wlast = 16'h0;
  end
  always @(posedge clock) begin
    if (address_strobe_n) begin
      cnt <= 4'h0;
      port_width_ack_n <= 2'h3;
      bus_fault_n <= 1'b1;
      // released bus changes every cycle
      data_in <= ~data_in;
    end else if (!data_strobe_n) begin
      cnt <= cnt + 4'h1;
      if (read_write) begin
        data_in <= port8 ? {pat(addr), ~pat(addr)} : addr[0] ? {~pat(addr), pat(addr)} :
          {pat(addr), pat(addr + 24'h1)};
      end
      if (cnt == wait_n) begin
        if (fault_mode) bus_fault_n <= 1'b0;
        else port_width_ack_n <= port8 ? 2'h2 : 2'h1;
        if (!read_write) wlast <= data_out;
      end
    end
  end
endmodule
